// ==== verilog/dbg_pkg.sv ====
// package of offsets, field positions and reset values for the dual bank gpio port
package dbg_pkg;
    // ****************************************
    // register offsets (16-bit address port)
    // ****************************************
    localparam logic [15:0] DBG_CTRL_OFS     = 16'hc006;
    localparam logic [15:0] DBG_B0_OUT_OFS   = 16'hc01e;
    localparam logic [15:0] DBG_B0_IN_OFS    = 16'hc020;
    localparam logic [15:0] DBG_B0_DIR_OFS   = 16'hc022;
    localparam logic [15:0] DBG_B1_OUT_OFS   = 16'hc024;
    localparam logic [15:0] DBG_B1_IN_OFS    = 16'hc026;
    localparam logic [15:0] DBG_B1_DIR_OFS   = 16'hc028;
    localparam logic [15:0] DBG_IRQ_STAT_OFS = 16'hc030;
    localparam logic [15:0] DBG_IRQ_MASK_OFS = 16'hc032;
    localparam logic [15:0] DBG_CPU_IEN_OFS  = 16'hc034;

    // ****************************************
    // field positions and masks
    // ****************************************
    localparam int          DBG_CTRL_IEN_BIT = 0;
    localparam int          DBG_CTRL_POL_BIT = 1;
    localparam int          DBG_CTRL_WP_BIT  = 15;
    localparam int          DBG_MODE_LSB     = 8;
    localparam logic [15:0] DBG_CTRL_LO_MASK = 16'h00a3;
    localparam logic [15:0] DBG_CTRL_HI_MASK = 16'h8f00;
    localparam logic [15:0] DBG_B1_MASK      = 16'he1f8;
    localparam int          DBG_IRQ_PIN_BIT  = 8;
    localparam logic [2:0]  DBG_MODE_GPIO    = 3'h0;
    localparam logic [2:0]  DBG_MODE_HOST    = 3'h5;
    localparam logic [15:0] DBG_B1_MODE_MASK = 16'h01f8;
    localparam int          DBG_EV_EDGE_BIT  = 0;
    localparam int          DBG_EV_IN_BIT    = 1;
    localparam logic [15:0] DBG_EV_MASK      = 16'h0003;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] DBG_REG_RST      = 16'h0000;
endpackage : dbg_pkg

// ==== verilog/dbg_edge_det.sv ====
// edge detector with selectable polarity
`timescale 1ns/10ps
module dbg_edge_det
    import dbg_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rst_b_i,
    input  wire logic level_i,
    input  wire logic rise_sel_i,
    output logic      edge_o
);
    logic prev_reg;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level_i;
        end
    end

    // rise when selected, else fall
    assign edge_o = rise_sel_i ? (level_i & ~prev_reg) : (~level_i & prev_reg);
endmodule : dbg_edge_det

// ==== verilog/dbg_pin_bank.sv ====
// one bank of pin registers: output data, direction, pin sampling
`timescale 1ns/10ps
module dbg_pin_bank
    import dbg_pkg::*;
#(
    parameter logic [15:0] IMPL_MASK = 16'hffff,
    parameter logic [15:0] MODE_MASK = 16'hffff
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        wr_out_i,
    input  wire logic        wr_dir_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [15:0] pin_i,
    input  wire logic        gpio_en_i,
    output logic      [15:0] out_data_o,
    output logic      [15:0] dir_o,
    output logic      [15:0] in_data_o,
    output logic      [15:0] pin_o,
    output logic      [15:0] pin_oe_o
);
    logic [15:0] out_reg;
    logic [15:0] dir_reg;
    logic [15:0] in_reg;
    logic [15:0] pin_reg;
    logic [15:0] oe_reg;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_reg <= DBG_REG_RST;
        end else if (wr_out_i) begin
            out_reg <= wdata_i & IMPL_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dir_reg <= DBG_REG_RST;
        end else if (wr_dir_i) begin
            dir_reg <= wdata_i & IMPL_MASK;
        end
    end

    // input level sampled every cycle, no write path
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            in_reg <= DBG_REG_RST;
        end else begin
            in_reg <= pin_i & IMPL_MASK;
        end
    end

    // pin drivers registered so outputs come from flops
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_reg <= DBG_REG_RST;
            oe_reg  <= DBG_REG_RST;
        end else begin
            pin_reg <= wr_out_i ? (wdata_i & IMPL_MASK) : out_reg;
            // pins owned by another mode keep their driver released
            oe_reg  <= (wr_dir_i ? (wdata_i & IMPL_MASK) : dir_reg)
                       & (gpio_en_i ? 16'hffff : ~MODE_MASK);
        end
    end

    assign out_data_o = out_reg;
    assign dir_o      = dir_reg;
    assign in_data_o  = in_reg;
    assign pin_o      = pin_reg;
    assign pin_oe_o   = oe_reg;
endmodule : dbg_pin_bank

// ==== verilog/dbg_gpio_port.sv ====
// top of the dual bank gpio port with register port and pin interrupt
// How it works
// - pin interrupt passes only when control bit 0 and cpu enable are both set
// - bank 0 bits 15..0; bank 1 bits 15..13, 8, 7..3 implemented
// - output data reads back the last written value
// - output data bit drives pin high for one, low for zero
// - input data registers show pin levels, writes ignored
// - direction one makes pin output in mode 000 (in other modes only bank 1 bits 15..13), zero releases the driver
// - polarity bit picks rising edge when one, falling when zero
// - mode field 10..8: 000 general purpose, 101 host port interface
// - write protect bit freezes control bits 15 and 11..8 until reset
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module dbg_gpio_port
    import dbg_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic [15:0] bank0_pin_i,
    output logic      [15:0] bank0_pin_o,
    output logic      [15:0] bank0_pin_oe_o,
    input  wire logic [15:0] bank1_pin_i,
    output logic      [15:0] bank1_pin_o,
    output logic      [15:0] bank1_pin_oe_o,
    output logic      [2:0]  mode_o,
    output logic             host_port_interface_sel_o,
    output logic             external_pin_interrupt_o,
    output logic             irq_o
);
    // ****************************************
    // decode
    // ****************************************
    logic wr_ctrl;
    logic wr_b0_out;
    logic wr_b0_dir;
    logic wr_b1_out;
    logic wr_b1_dir;
    logic wr_mask;
    logic wr_cpu_ien;
    logic rd_stat;
    logic gpio_mode;

    assign wr_ctrl    = wr_i && (addr_i == DBG_CTRL_OFS);
    assign wr_b0_out  = wr_i && (addr_i == DBG_B0_OUT_OFS);
    assign wr_b0_dir  = wr_i && (addr_i == DBG_B0_DIR_OFS);
    assign wr_b1_out  = wr_i && (addr_i == DBG_B1_OUT_OFS);
    assign wr_b1_dir  = wr_i && (addr_i == DBG_B1_DIR_OFS);
    assign wr_mask    = wr_i && (addr_i == DBG_IRQ_MASK_OFS);
    assign wr_cpu_ien = wr_i && (addr_i == DBG_CPU_IEN_OFS);
    assign rd_stat    = rd_i && (addr_i == DBG_IRQ_STAT_OFS);

    // ****************************************
    // control register
    // ****************************************
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic        cpu_ien_reg;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = (ctrl_reg & ~DBG_CTRL_LO_MASK) | (wdata_i & DBG_CTRL_LO_MASK);
            if (!ctrl_reg[DBG_CTRL_WP_BIT]) begin
                ctrl_next = (ctrl_next & ~DBG_CTRL_HI_MASK) | (wdata_i & DBG_CTRL_HI_MASK);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_reg <= DBG_REG_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // gpio enable bit of the processor interrupt enable register
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cpu_ien_reg <= 1'b0;
        end else if (wr_cpu_ien) begin
            cpu_ien_reg <= wdata_i[0];
        end
    end

    // mode field steers pin ownership
    assign gpio_mode = (ctrl_reg[DBG_MODE_LSB +: 3] == DBG_MODE_GPIO);

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_o                    <= DBG_MODE_GPIO;
            host_port_interface_sel_o <= 1'b0;
        end else begin
            mode_o                    <= ctrl_reg[DBG_MODE_LSB +: 3];
            host_port_interface_sel_o <= (ctrl_reg[DBG_MODE_LSB +: 3] == DBG_MODE_HOST);
        end
    end

    // ****************************************
    // pin banks
    // ****************************************
    logic [15:0] b0_out;
    logic [15:0] b0_dir;
    logic [15:0] b0_in;
    logic [15:0] b1_out;
    logic [15:0] b1_dir;
    logic [15:0] b1_in;

    dbg_pin_bank #(
        .IMPL_MASK (16'hffff),
        .MODE_MASK (16'hffff)
    ) u_bank0 (
        .ref_clk_i  (ref_clk_i),
        .rst_b_i    (rst_b_i),
        .wr_out_i   (wr_b0_out),
        .wr_dir_i   (wr_b0_dir),
        .wdata_i    (wdata_i),
        .pin_i      (bank0_pin_i),
        .gpio_en_i  (gpio_mode),
        .out_data_o (b0_out),
        .dir_o      (b0_dir),
        .in_data_o  (b0_in),
        .pin_o      (bank0_pin_o),
        .pin_oe_o   (bank0_pin_oe_o)
    );

    dbg_pin_bank #(
        .IMPL_MASK (DBG_B1_MASK),
        .MODE_MASK (DBG_B1_MODE_MASK)
    ) u_bank1 (
        .ref_clk_i  (ref_clk_i),
        .rst_b_i    (rst_b_i),
        .wr_out_i   (wr_b1_out),
        .wr_dir_i   (wr_b1_dir),
        .wdata_i    (wdata_i),
        .pin_i      (bank1_pin_i),
        .gpio_en_i  (gpio_mode),
        .out_data_o (b1_out),
        .dir_o      (b1_dir),
        .in_data_o  (b1_in),
        .pin_o      (bank1_pin_o),
        .pin_oe_o   (bank1_pin_oe_o)
    );

    // ****************************************
    // pin interrupt
    // ****************************************
    logic pin_edge;
    logic ev_edge;

    dbg_edge_det u_edge (
        .ref_clk_i  (ref_clk_i),
        .rst_b_i    (rst_b_i),
        .level_i    (b1_in[DBG_IRQ_PIN_BIT]),
        .rise_sel_i (ctrl_reg[DBG_CTRL_POL_BIT]),
        .edge_o     (pin_edge)
    );

    assign ev_edge = pin_edge && ctrl_reg[DBG_CTRL_IEN_BIT] && cpu_ien_reg;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            external_pin_interrupt_o <= 1'b0;
        end else begin
            external_pin_interrupt_o <= ev_edge;
        end
    end

    // ****************************************
    // status and mask
    // ****************************************
    logic [15:0] stat_reg;
    logic [15:0] mask_reg;
    logic [15:0] ev_set;

    always_comb begin
        ev_set                  = 16'h0000;
        ev_set[DBG_EV_EDGE_BIT] = ev_edge;
        ev_set[DBG_EV_IN_BIT]   = (b0_in != bank0_pin_i) || (b1_in != (bank1_pin_i & DBG_B1_MASK));
    end

    // set wins over clear-on-read
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stat_reg <= DBG_REG_RST;
        end else begin
            stat_reg <= (rd_stat ? 16'h0000 : stat_reg) | ev_set;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_reg <= DBG_REG_RST;
        end else if (wr_mask) begin
            mask_reg <= wdata_i & DBG_EV_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((rd_stat ? 16'h0000 : stat_reg) | ev_set) & mask_reg);
        end
    end

    // ****************************************
    // read port
    // ****************************************
    logic [15:0] rd_mux;

    always_comb begin
        unique case (addr_i)
            DBG_CTRL_OFS:     rd_mux = ctrl_reg;
            DBG_B0_OUT_OFS:   rd_mux = b0_out;
            DBG_B0_IN_OFS:    rd_mux = b0_in;
            DBG_B0_DIR_OFS:   rd_mux = b0_dir;
            DBG_B1_OUT_OFS:   rd_mux = b1_out;
            DBG_B1_IN_OFS:    rd_mux = b1_in;
            DBG_B1_DIR_OFS:   rd_mux = b1_dir;
            DBG_IRQ_STAT_OFS: rd_mux = stat_reg;
            DBG_IRQ_MASK_OFS: rd_mux = mask_reg;
            DBG_CPU_IEN_OFS:  rd_mux = {15'h0000, cpu_ien_reg};
            default:          rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            rdata_o <= rd_mux;
        end else begin
            rdata_o <= 16'h0000;
        end
    end
endmodule : dbg_gpio_port

// ==== verif/dbg_gpio_chk_asserts.sv ====
// port checker of the dual bank gpio port
`timescale 1ns/10ps
module dbg_gpio_chk
    import dbg_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        rst_b_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic [15:0] bank0_pin_o,
    input wire logic [15:0] bank0_pin_oe_o,
    input wire logic [15:0] bank1_pin_oe_o,
    input wire logic [2:0]  mode_o,
    input wire logic        host_port_interface_sel_o,
    input wire logic        external_pin_interrupt_o,
    input wire logic        irq_o
);
    // ****************
    // port relations
    // ****************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_rdata_idle:
        assert property (!$past(rd_i) |-> rdata_o == 16'h0000) else $error("stray data");
    a_out_drive:
        assert property (wr_i && addr_i == DBG_B0_OUT_OFS |=> bank0_pin_o == $past(wdata_i))
            else $error("pin drive");
    a_dir_enable:
        assert property (wr_i && addr_i == DBG_B0_DIR_OFS
            |=> bank0_pin_oe_o == ((mode_o == DBG_MODE_GPIO) ? $past(wdata_i) : 16'h0000))
            else $error("pin enable");
    a_bank1_holes:
        assert property ((bank1_pin_oe_o & ~DBG_B1_MASK) == 16'h0000) else $error("hole");
    a_pulse_single:
        assert property (external_pin_interrupt_o |=> !external_pin_interrupt_o)
            else $error("long pulse");
    a_host_select:
        assert property (host_port_interface_sel_o == (mode_o == DBG_MODE_HOST))
            else $error("host select");
    a_mode_release:
        assert property (mode_o != DBG_MODE_GPIO && $past(mode_o) != DBG_MODE_GPIO
            |-> bank0_pin_oe_o == 16'h0000 && (bank1_pin_oe_o & DBG_B1_MODE_MASK) == 16'h0000)
            else $error("mode enable");
    a_reset_clear:
        assert property (!$past(rst_b_i) |-> bank0_pin_oe_o == 16'h0000 && !irq_o
            && bank1_pin_oe_o == 16'h0000) else $error("reset state");
endmodule : dbg_gpio_chk

// ==== verif/dbg_pin_model.sv ====
// pins with the outside circuitry of both banks
`timescale 1ns/10ps
module dbg_pin_model (
    input  wire logic [15:0] drv0_i,
    input  wire logic [15:0] oe0_i,
    input  wire logic [15:0] ext0_i,
    input  wire logic [15:0] drv1_i,
    input  wire logic [15:0] oe1_i,
    input  wire logic [15:0] ext1_i,
    output logic      [15:0] lvl0_o,
    output logic      [15:0] lvl1_o
);
    // released bits follow the outside circuit
    assign lvl0_o = (oe0_i & drv0_i) | (~oe0_i & ext0_i);
    assign lvl1_o = (oe1_i & drv1_i) | (~oe1_i & ext1_i);
endmodule : dbg_pin_model

// ==== verif/tb_top.sv ====
// self-checking bench of the dual bank gpio port
`timescale 1ns/10ps
module tb_top
    import dbg_pkg::*;
;
    logic        ref_clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [15:0] wdata_i = 16'h0000;
    logic [15:0] ext0 = 16'h0000;
    logic [15:0] ext1 = 16'h0000;
    logic [15:0] rdata_o, bank0_pin_i, bank0_pin_o, bank0_pin_oe_o, v;
    logic [15:0] bank1_pin_i, bank1_pin_o, bank1_pin_oe_o;
    logic [15:0] wv [4];
    logic [2:0]  mode_o;
    logic        host_port_interface_sel_o, external_pin_interrupt_o, irq_o;
    int          n_fail = 0, tests_run = 0, seed = 16672, k;
    logic [15:0] wofs [4] = '{DBG_B0_OUT_OFS, DBG_B0_DIR_OFS, DBG_B1_OUT_OFS, DBG_B1_DIR_OFS};
    logic [15:0] rofs [7] = '{DBG_CTRL_OFS, DBG_B0_IN_OFS, DBG_B1_IN_OFS, DBG_IRQ_STAT_OFS,
                              DBG_IRQ_MASK_OFS, DBG_CPU_IEN_OFS, 16'hc002};

    always #2 ref_clk_i = ~ref_clk_i;

    dbg_gpio_port dut (.ref_clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .bank0_pin_i, .bank0_pin_o, .bank0_pin_oe_o, .bank1_pin_i, .bank1_pin_o, .mode_o,
        .bank1_pin_oe_o, .host_port_interface_sel_o, .external_pin_interrupt_o, .irq_o);
    dbg_pin_model pins (.drv0_i(bank0_pin_o), .oe0_i(bank0_pin_oe_o), .ext0_i(ext0),
        .lvl0_o(bank0_pin_i), .drv1_i(bank1_pin_o), .oe1_i(bank1_pin_oe_o), .ext1_i(ext1),
        .lvl1_o(bank1_pin_i));

    // ****************
    // bus and checks
    // ****************
    task automatic chk(input logic [15:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, d);
        @(posedge ref_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : rd
    task automatic do_reset;
        @(posedge ref_clk_i);
        rst_b_i <= 1'b0;
        repeat (12) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
    endtask : do_reset
    function automatic logic [15:0] lvl(input logic [15:0] dir, dat, ext);
        return (dir & dat) | (~dir & ext);
    endfunction : lvl
    task automatic irq_try(input logic [15:0] ctl, input logic ien, msk, lv, exp);
        logic hit, req;
        hit = 1'b0;
        req = 1'b0;
        wr(DBG_CTRL_OFS, ctl);
        wr(DBG_CPU_IEN_OFS, {15'h0, ien});
        wr(DBG_IRQ_MASK_OFS, {15'h0, msk});
        ext1[8] <= ~lv;
        repeat (3) @(posedge ref_clk_i);
        rd(DBG_IRQ_STAT_OFS);
        @(posedge ref_clk_i);
        ext1[8] <= lv;
        repeat (6) begin
            @(posedge ref_clk_i);
            #1;
            hit |= external_pin_interrupt_o;
            req |= irq_o;
        end
        chk({15'h0, hit}, {15'h0, exp}, "pin event");
        chk({15'h0, req}, {15'h0, exp & msk}, "irq level");
        rd(DBG_IRQ_STAT_OFS);
        chk(v & 16'h0001, {15'h0, exp}, "status");
        @(posedge ref_clk_i);
        #1 chk({15'h0, irq_o}, 16'h0000, "irq clear");
    endtask : irq_try
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // ****************
    // scenarios
    // ****************
    initial begin
        do_reset();
        foreach (rofs[i]) begin
            rd(rofs[i]);
            chk(v, 16'h0000, "reset");
        end
        foreach (wofs[i]) begin
            rd(wofs[i]);
            chk(v, 16'h0000, "reset");
        end
        $display("reset test done");
        repeat (24) begin
            foreach (wv[i]) wv[i] = 16'($random(seed)) & (i > 1 ? DBG_B1_MASK : 16'hffff);
            foreach (wv[i]) wr(wofs[i], wv[i]);
            ext0 <= 16'($random(seed));
            ext1 <= 16'($random(seed));
            wr(DBG_B0_IN_OFS, 16'hffff);
            wr(DBG_B1_IN_OFS, 16'hffff);
            foreach (wv[i]) begin
                rd(wofs[i]);
                chk(v, wv[i], "readback");
            end
            rd(DBG_B0_IN_OFS);
            chk(v, lvl(wv[1], wv[0], ext0), "bank0 in");
            rd(DBG_B1_IN_OFS);
            chk(v, lvl(wv[3], wv[2], ext1) & DBG_B1_MASK, "bank1 in");
            chk(bank0_pin_o, wv[0], "drive");
            chk(bank0_pin_oe_o, wv[1], "enable");
            chk(bank1_pin_oe_o, wv[3], "enable1");
            chk(bank1_pin_o, wv[2], "drive1");
        end
        $display("register test done");
        for (k = 0; k < 8; k++) begin
            wr(DBG_CTRL_OFS, {5'h00, k[2:0], 8'h00});
            @(posedge ref_clk_i);
            #1 chk({13'h0, mode_o}, {13'h0, k[2:0]}, "mode");
            chk(bank0_pin_oe_o, (k == 0) ? wv[1] : 16'h0000, "mode oe");
            chk(bank1_pin_oe_o, (k == 0) ? wv[3] : (wv[3] & ~DBG_B1_MODE_MASK), "mode oe1");
            chk({15'h0, host_port_interface_sel_o}, {15'h0, (k[2:0] == DBG_MODE_HOST)}, "host");
        end
        $display("mode test done");
        wr(DBG_B1_DIR_OFS, 16'h0000);
        irq_try(16'h0003, 1'b1, 1'b1, 1'b1, 1'b1);
        irq_try(16'h0003, 1'b1, 1'b1, 1'b0, 1'b0);
        irq_try(16'h0001, 1'b1, 1'b0, 1'b0, 1'b1);
        irq_try(16'h0002, 1'b1, 1'b1, 1'b1, 1'b0);
        irq_try(16'h0003, 1'b0, 1'b1, 1'b1, 1'b0);
        $display("interrupt test done");
        wr(DBG_CTRL_OFS, 16'h8500);
        wr(DBG_CTRL_OFS, 16'h0003);
        rd(DBG_CTRL_OFS);
        chk(v, 16'h8503, "protect");
        do_reset();
        wr(DBG_CTRL_OFS, 16'h0500);
        rd(DBG_CTRL_OFS);
        chk(v, 16'h0500, "unfrozen");
        $display("protect test done");
        wrap_up();
    end
endmodule : tb_top

bind dbg_gpio_port dbg_gpio_chk chk_i (.ref_clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .bank0_pin_o, .bank0_pin_oe_o, .bank1_pin_oe_o, .mode_o, .irq_o,
    .host_port_interface_sel_o, .external_pin_interrupt_o);
